// *** gaebc_pkg.sv ***
// Package for the gain and echo balance configuration bank.
// Assumes a single 10 MHz system clock and a host that writes whole bytes.
package gaebc_pkg;
   // Register selection codes on the write port
   localparam logic [2:0] GAEBC_SEL_TX_GAIN = 3'h0;
   localparam logic [2:0] GAEBC_SEL_RX_GAIN = 3'h1;
   localparam logic [2:0] GAEBC_SEL_ECHO_CTRL = 3'h2;
   localparam logic [2:0] GAEBC_SEL_ECHO_LOW = 3'h3;
   localparam logic [2:0] GAEBC_SEL_ECHO_HIGH = 3'h4;
   localparam int GAEBC_NREGS = 5;
   // Power-on values: no output, cancellation off
   localparam logic [7:0] GAEBC_GAIN_RST = 8'h00;
   localparam logic [7:0] GAEBC_ECHO_RST = 8'h00;
   localparam logic [7:0] GAEBC_GAIN_MUTE = 8'h00;
   localparam logic [7:0] GAEBC_LOW_BYPASS = 8'h00;
   // Gain code offsets: transmit and receive
   localparam int GAEBC_TX_OFFSET = 191;
   localparam int GAEBC_RX_OFFSET = 174;
   // Control register field positions
   localparam int GAEBC_BIT_ENABLE = 7;
   localparam int GAEBC_BIT_NOINV = 6;
   localparam int GAEBC_BIT_HIGH_EN = 5;
   localparam int GAEBC_ATT_MSB = 4;
   localparam logic [4:0] GAEBC_ATT_MAX = 5'h18;
endpackage : gaebc_pkg

// *** gaebc_reg8.sv ***
// One eight-bit configuration register with synchronous clear.
// Assumes the write strobe comes from logic on the same clock.
module gaebc_reg8
   import gaebc_pkg::*;
#(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Write side
   input wire logic wr_i,
   input wire logic [7:0] data_i,
   // Stored value
   output logic [7:0] q_o
);
   logic [7:0] val_ff;
   logic [7:0] nxt_val;

   // Hold whole byte until next write
   always_comb begin
      nxt_val = wr_i ? data_i : val_ff; // RQ15
   end

   // Register stage
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         val_ff <= RST_VAL;
      end else begin
         val_ff <= nxt_val;
      end
   end

   assign q_o = val_ff;
endmodule : gaebc_reg8

// *** gaebc_top.sv ***
// Gain and echo balance configuration bank of a voice codec.
// Assumes the control port has already decoded the instruction and
// delivers byte 2 with a one-cycle write strobe and a register select.
// How it works
// RQ1 - The transmit gain code sets the transmit level in 0.1 dB steps with code offset 191.
// RQ2 - Transmit code zero mutes, code one is -19 dBm and all ones is +6.4 dBm.
// RQ3 - The receive gain code sets the receive level in 0.1 dB steps, one step per code.
// RQ4 - The host computes the receive code with offset 174 and writes it in binary.
// RQ5 - Receive code zero mutes, code one is -17.3 dBm and all ones is +8.1 dBm.
// RQ6 - Control bit 7 low turns all cancellation off, high turns it on.
// RQ7 - Control bit 6 picks inverted echo phase when low and no inversion when high.
// RQ8 - Control bit 5 bypasses the high band section when low and enables it when high.
// RQ9 - Control bits 4 to 0 set the cancellation attenuation from -2.5 dB to -8.5 dB.
// RQ10 - After power-up the cancellation filter stays disabled until programmed.
// RQ11 - A low band setting of all zeros bypasses the low band section, else it is active.
// RQ12 - The high band setting holds its pole and zero codes independently.
// RQ13 - The host programs all three echo balance registers for a full setup.
// RQ14 - Each setting arrives as byte 2 of a two-byte control instruction.
// RQ15 - Each written byte is stored whole and shown unchanged until rewritten or reset.
module gaebc_top
   import gaebc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Byte 2 write port from control interface
   input wire logic wr_i,
   input wire logic [2:0] sel_i,
   input wire logic [7:0] wdata_i,
   // Read port
   input wire logic [2:0] rsel_i,
   output logic [7:0] rdata_o,
   // Gain stage controls
   output logic [7:0] transmit_gain_o,
   output logic [7:0] receive_gain_o,
   output logic transmit_mute_o,
   output logic receive_mute_o,
   // Cancellation path controls
   output logic [7:0] echo_balance_control_o,
   output logic [7:0] echo_low_band_setting_o,
   output logic [7:0] echo_high_band_setting_o,
   output logic echo_enable_o,
   output logic echo_noninvert_o,
   output logic high_band_enable_o,
   output logic low_band_enable_o,
   output logic [4:0] cancellation_attenuation_field_o
);
   logic [7:0] regs_q [GAEBC_NREGS];
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;

   // One register per selection code
   genvar gi;
   generate
      for (gi = 0; gi < GAEBC_NREGS; gi++) begin : g_reg
         gaebc_reg8 #(
            .RST_VAL(gi < int'(GAEBC_SEL_ECHO_CTRL) ? GAEBC_GAIN_RST : GAEBC_ECHO_RST) // RQ10
         ) u_reg (
            .clk_sys_i(clk_sys_i),
            .resetn_i(resetn_i),
            .wr_i(wr_i && (sel_i == 3'(gi))), // RQ14
            .data_i(wdata_i),
            .q_o(regs_q[gi])
         );
      end
   endgenerate

   // Read mux, unmapped reads as zero
   always_comb begin
      if (rsel_i == GAEBC_SEL_TX_GAIN) begin
         nxt_rdata = regs_q[GAEBC_SEL_TX_GAIN];
      end else if (rsel_i == GAEBC_SEL_RX_GAIN) begin
         nxt_rdata = regs_q[GAEBC_SEL_RX_GAIN];
      end else if (rsel_i == GAEBC_SEL_ECHO_CTRL) begin
         nxt_rdata = regs_q[GAEBC_SEL_ECHO_CTRL];
      end else if (rsel_i == GAEBC_SEL_ECHO_LOW) begin
         nxt_rdata = regs_q[GAEBC_SEL_ECHO_LOW];
      end else if (rsel_i == GAEBC_SEL_ECHO_HIGH) begin
         nxt_rdata = regs_q[GAEBC_SEL_ECHO_HIGH];
      end else begin
         nxt_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Stored codes drive the analogue stages directly
   assign rdata_o = rdata_ff;
   assign transmit_gain_o = regs_q[GAEBC_SEL_TX_GAIN]; // RQ1
   assign receive_gain_o = regs_q[GAEBC_SEL_RX_GAIN]; // RQ3
   assign echo_balance_control_o = regs_q[GAEBC_SEL_ECHO_CTRL];
   assign echo_low_band_setting_o = regs_q[GAEBC_SEL_ECHO_LOW];
   assign echo_high_band_setting_o = regs_q[GAEBC_SEL_ECHO_HIGH]; // RQ12

   // Decoded flags held in flip-flops so outputs stay registered
   logic tx_mute_ff, rx_mute_ff, en_ff, noinv_ff, hi_ff, lo_ff;
   logic nxt_tx_mute, nxt_rx_mute, nxt_en, nxt_noinv, nxt_hi, nxt_lo;
   logic [4:0] att_ff;
   logic [4:0] nxt_att;

   // Decode the value each register will hold next cycle
   always_comb begin
      logic [7:0] ctl;
      ctl = (wr_i && sel_i == GAEBC_SEL_ECHO_CTRL) ? wdata_i : regs_q[GAEBC_SEL_ECHO_CTRL];
      nxt_tx_mute = (wr_i && sel_i == GAEBC_SEL_TX_GAIN) ? (wdata_i == GAEBC_GAIN_MUTE)
                    : (regs_q[GAEBC_SEL_TX_GAIN] == GAEBC_GAIN_MUTE); // RQ2
      nxt_rx_mute = (wr_i && sel_i == GAEBC_SEL_RX_GAIN) ? (wdata_i == GAEBC_GAIN_MUTE)
                    : (regs_q[GAEBC_SEL_RX_GAIN] == GAEBC_GAIN_MUTE); // RQ5
      nxt_en = ctl[GAEBC_BIT_ENABLE]; // RQ6
      nxt_noinv = ctl[GAEBC_BIT_NOINV]; // RQ7
      nxt_hi = ctl[GAEBC_BIT_ENABLE] & ctl[GAEBC_BIT_HIGH_EN]; // RQ8
      nxt_att = ctl[GAEBC_ATT_MSB:0]; // RQ9
      nxt_lo = ctl[GAEBC_BIT_ENABLE] &&
               (((wr_i && sel_i == GAEBC_SEL_ECHO_LOW) ? wdata_i
                 : regs_q[GAEBC_SEL_ECHO_LOW]) != GAEBC_LOW_BYPASS); // RQ11
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         // Flags follow the power-on codes so they never disagree with them
         tx_mute_ff <= (GAEBC_GAIN_RST == GAEBC_GAIN_MUTE);
         rx_mute_ff <= (GAEBC_GAIN_RST == GAEBC_GAIN_MUTE);
         en_ff <= GAEBC_ECHO_RST[GAEBC_BIT_ENABLE]; // RQ10
         noinv_ff <= GAEBC_ECHO_RST[GAEBC_BIT_NOINV];
         hi_ff <= GAEBC_ECHO_RST[GAEBC_BIT_ENABLE] & GAEBC_ECHO_RST[GAEBC_BIT_HIGH_EN];
         lo_ff <= 1'b0;
         att_ff <= GAEBC_ECHO_RST[GAEBC_ATT_MSB:0];
      end else begin
         tx_mute_ff <= nxt_tx_mute;
         rx_mute_ff <= nxt_rx_mute;
         en_ff <= nxt_en;
         noinv_ff <= nxt_noinv;
         hi_ff <= nxt_hi;
         lo_ff <= nxt_lo;
         att_ff <= nxt_att;
      end
   end

   assign transmit_mute_o = tx_mute_ff;
   assign receive_mute_o = rx_mute_ff;
   assign echo_enable_o = en_ff;
   assign echo_noninvert_o = noinv_ff;
   assign high_band_enable_o = hi_ff;
   assign low_band_enable_o = lo_ff;
   assign cancellation_attenuation_field_o = att_ff;

   // Checks
   property p_store;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      wr_i && sel_i == GAEBC_SEL_TX_GAIN |=> transmit_gain_o == $past(wdata_i);
   endproperty
   a_store: assert property (p_store) else $error("tx gain not stored"); // RQ15
   property p_hold;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      !(wr_i && sel_i == GAEBC_SEL_RX_GAIN) |=> $stable(receive_gain_o);
   endproperty
   a_hold: assert property (p_hold) else $error("rx gain changed"); // RQ15
   property p_txmute;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      transmit_mute_o == (transmit_gain_o == GAEBC_GAIN_MUTE);
   endproperty
   a_txmute: assert property (p_txmute) else $error("tx mute wrong"); // RQ2
   property p_rxmute;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      receive_mute_o == (receive_gain_o == GAEBC_GAIN_MUTE);
   endproperty
   a_rxmute: assert property (p_rxmute) else $error("rx mute wrong"); // RQ5
   property p_en;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      echo_enable_o == echo_balance_control_o[GAEBC_BIT_ENABLE];
   endproperty
   a_en: assert property (p_en) else $error("enable wrong"); // RQ6
   property p_inv;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      echo_noninvert_o == echo_balance_control_o[GAEBC_BIT_NOINV];
   endproperty
   a_inv: assert property (p_inv) else $error("phase wrong"); // RQ7
   property p_hi;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      high_band_enable_o == (echo_balance_control_o[GAEBC_BIT_HIGH_EN] &&
                             echo_balance_control_o[GAEBC_BIT_ENABLE]);
   endproperty
   a_hi: assert property (p_hi) else $error("high band wrong"); // RQ8
   property p_att;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      cancellation_attenuation_field_o == echo_balance_control_o[GAEBC_ATT_MSB:0];
   endproperty
   a_att: assert property (p_att) else $error("attenuation wrong"); // RQ9
   property p_lo;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      low_band_enable_o == (echo_balance_control_o[GAEBC_BIT_ENABLE] &&
                            echo_low_band_setting_o != GAEBC_LOW_BYPASS);
   endproperty
   a_lo: assert property (p_lo) else $error("low band not bypassed"); // RQ11
   property p_rst;
      @(posedge clk_sys_i) !resetn_i |=> !echo_enable_o && echo_balance_control_o == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("filter not off after reset"); // RQ10
   c_tx: cover property (@(posedge clk_sys_i) wr_i && sel_i == GAEBC_SEL_TX_GAIN);
   c_en: cover property (@(posedge clk_sys_i) $rose(echo_enable_o));
   c_lo: cover property (@(posedge clk_sys_i) $rose(low_band_enable_o));
   c_att: cover property (@(posedge clk_sys_i) cancellation_attenuation_field_o == GAEBC_ATT_MAX);
endmodule : gaebc_top

// *** gaebc_host_model.sv ***
// Host model that writes byte 2 of control instructions into the bank.
// Assumes each call starts just after a rising edge of the system clock.
module gaebc_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Byte 2 write port
   output logic wr_o,
   output logic [2:0] sel_o,
   output logic [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle port at time zero
   initial begin
      wr_o = 1'b0;
      sel_o = 3'h0;
      wdata_o = 8'h00;
   end
   // Present one byte 2 and hold it across the sampling edge
   task automatic write_byte(input logic [2:0] s, input logic [7:0] d);
      wr_o <= 1'b1;
      sel_o <= s;
      wdata_o <= d;
      @(posedge clk_sys_i);
   endtask : write_byte
   // Release the port; stale data is inverted so it cannot pass for valid
   task automatic release_port();
      wr_o <= 1'b0;
      wdata_o <= ~wdata_o;
      @(posedge clk_sys_i);
   endtask : release_port
endmodule : gaebc_host_model

// *** testbench.sv ***
// Self-checking bench for the gain and echo balance configuration bank.
// Assumes the bank and the host model files are compiled before it.
module testbench;
   import gaebc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i, resetn_i, wr_i, rreq, w, r, rst;
   logic [2:0] sel_i, rsel_i;
   logic [7:0] wdata_i, rdata_o, tx_o, rx_o, ctl_o, lo_o, hi_o;
   logic txm_o, rxm_o, en_o, ninv_o, hen_o, len_o;
   logic [4:0] att_o;
   logic [10:0] wq[$];
   logic [7:0] rq[$];
   logic [7:0] sh[8], msh[8];
   logic [10:0] n;
   logic [7:0] gc[5] = '{8'h00, 8'h01, 8'(GAEBC_TX_OFFSET), 8'(GAEBC_RX_OFFSET), 8'hFF};
   int fails, tests_run;
   // Design and host
   gaebc_top gaebc_top_inst (.clk_sys_i, .resetn_i, .wr_i, .sel_i, .wdata_i, .rsel_i,
      .rdata_o, .transmit_gain_o(tx_o), .receive_gain_o(rx_o), .transmit_mute_o(txm_o),
      .receive_mute_o(rxm_o), .echo_balance_control_o(ctl_o), .echo_low_band_setting_o(lo_o),
      .echo_high_band_setting_o(hi_o), .echo_enable_o(en_o), .echo_noninvert_o(ninv_o),
      .high_band_enable_o(hen_o), .low_band_enable_o(len_o),
      .cancellation_attenuation_field_o(att_o));
   gaebc_host_model gaebc_host_model_inst (.clk_sys_i, .wr_o(wr_i), .sel_o(sel_i),
      .wdata_o(wdata_i));
   // Clock
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // Compare tasks for bytes and for flags
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp_f(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : cmp_f
   // All stage controls against the monitor's shadow copy
   task automatic chk_out();
      cmp(tx_o, msh[0]);
      cmp(rx_o, msh[1]);
      cmp(ctl_o, msh[2]);
      cmp(lo_o, msh[3]);
      cmp(hi_o, msh[4]);
      cmp_f(txm_o, msh[0] == 8'h00);
      cmp_f(rxm_o, msh[1] == 8'h00);
      cmp_f(en_o, msh[2][7]);
      cmp_f(ninv_o, msh[2][6]);
      cmp_f(hen_o, msh[2][7] & msh[2][5]);
      cmp({3'h0, att_o}, {3'h0, msh[2][4:0]});
      cmp_f(len_o, msh[2][7] && msh[3] != 8'h00);
   endtask : chk_out
   // Monitor: takes the oldest note whenever a write or read result appears
   always begin
      @(posedge clk_sys_i);
      w = resetn_i && wr_i && sel_i < 3'h5;
      r = resetn_i && rreq;
      rst = !resetn_i;
      #1;
      if (rst) begin
         msh = '{default: 8'h00};
      end
      if (w) begin
         n = wq.pop_front();
         msh[n[10:8]] = n[7:0];
      end
      // Every edge is checked, so ignored selects must leave all stages alone
      if (rst) chk_out();
      else chk_out();
      if (r) cmp(rdata_o, rq.pop_front());
   end
   // Driver tasks note each expectation before issuing
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      if (s < 3'h5) begin
         wq.push_back({s, d});
         sh[s] = d;
      end
      gaebc_host_model_inst.write_byte(s, d);
   endtask : wr
   task automatic rd_all();
      for (int i = 0; i < 8; i++) begin
         rsel_i <= i[2:0];
         rreq <= 1'b1;
         rq.push_back(sh[i]);
         @(posedge clk_sys_i);
      end
      rreq <= 1'b0;
      @(posedge clk_sys_i);
   endtask : rd_all
   task automatic end_sim();
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // Watchdog
   initial begin
      repeat (2000) @(posedge clk_sys_i);
      fails++;
      end_sim();
   end
   // Main sequence
   initial begin
      resetn_i = 1'b0;
      rsel_i = 3'h0;
      rreq = 1'b0;
      fails = 0;
      tests_run = 0;
      sh = '{default: 8'h00};
      void'($urandom(17006));
      repeat (8) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      rd_all();
      // Gain boundary codes back to back, 0 dBm codes included
      foreach (gc[i]) begin
         wr(3'h0, gc[i]);
         wr(3'h1, gc[i]);
      end
      // Every control bit combination, both attenuation ends, low band on and off
      for (int i = 0; i < 16; i++) begin
         wr(3'h3, i[0] ? 8'h5A : 8'h00);
         wr(3'h2, {i[3:1], i[0] ? 5'h18 : 5'h00});
         wr(3'h4, {i[3:0], ~i[3:0]});
      end
      gaebc_host_model_inst.release_port();
      rd_all();
      // Random writes, unmapped selects among them
      repeat (40) begin
         wr(3'($urandom), 8'($urandom));
         if ($urandom % 2) gaebc_host_model_inst.release_port();
      end
      gaebc_host_model_inst.release_port();
      rd_all();
      // Reset in mid-run clears everything
      resetn_i <= 1'b0;
      sh = '{default: 8'h00};
      repeat (2) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      rd_all();
      end_sim();
   end
endmodule : testbench
